// file: design/rsq_regs.vh
// Constants for the start-up reset sequencer and the option word.
// Assumes a 100 MHz system clock and inclusion by bare name.
`ifndef RSQ_REGS_VH
`define RSQ_REGS_VH

`define RSQ_CLK_MHZ          100
`define RSQ_PWRUP_DELAY_MS   72
`define RSQ_PWRUP_CYCLES     (`RSQ_PWRUP_DELAY_MS * 1000 * `RSQ_CLK_MHZ)
`define RSQ_OSC_SETTLE_CYC   1024
`define RSQ_WDOG_RC_TICKS    18
`define RSQ_OPT_ADDR         14'h2007
`define RSQ_CFG_BASE         14'h2000
`define RSQ_CFG_LAST         14'h3fff
`define RSQ_OPT_WIDTH        14
`define RSQ_OPT_ERASED       14'h3fff
`define RSQ_GUARD_LO_MSB     5
`define RSQ_GUARD_LO_LSB     4
`define RSQ_GUARD_HI_MSB     13
`define RSQ_GUARD_HI_LSB     12
`define RSQ_GUARD_OFF        2'h3
`define RSQ_BIT_WDOG_EN      2
`define RSQ_BIT_PWRUP_EN_N   3

`endif

// file: design/rsq_sync.v
// Two flip-flop synchroniser for a single level.
// Assumes the input is asynchronous to mclk_i.
`timescale 1ns/10ps
`default_nettype none
module rsq_sync (
    // Clock and reset.
    input  wire mclk_i,
    input  wire reset_n_i,
    // Level in and out.
    input  wire async_i,
    output wire sync_o
);
    reg meta_q;
    reg sync_q;

    // The first stage feeds only the second stage.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // rsq_sync
`default_nettype wire

// file: design/rsq_reset_seq.v
// Start-up reset sequencer, watchdog and option-word holder.
// Assumes a free-running 100 MHz mclk_i; reset_n_i is the power-on reset.
// Functional notes
// - Watchdog disable comes only from the option word, never from runtime writes.
// - Watchdog counts ticks of its own RC oscillator, not the system clock.
// - Core stays in reset until the oscillator settle timer has expired.
// - Power-up delay of 72 ms applies after power-up only.
// - Halt ends on external reset, watchdog timeout, or interrupt.
// - Programmed option bits read 0; unprogrammed bits read 1.
// - Option word lives at program address 2007h outside user space.
// - Space 2000h to 3FFFh is reachable only in programming mode.
// - Code guard field 11 means unprotected; other codes protect memory.
`timescale 1ns/10ps
`default_nettype none
`include "rsq_regs.vh"
module rsq_reset_seq #(
    parameter PWRUP_CYCLES  = `RSQ_PWRUP_CYCLES,
    parameter SETTLE_CYCLES = `RSQ_OSC_SETTLE_CYC,
    parameter WDOG_TICKS    = `RSQ_WDOG_RC_TICKS
) (
    // Clock and power-on reset.
    input  wire        mclk_i,
    input  wire        reset_n_i,
    // Asynchronous sources.
    input  wire        ext_reset_n_i,
    input  wire        wdog_rc_clk_i,
    input  wire        prog_mode_i,
    // Core side.
    input  wire        sleep_req_i,
    input  wire        irq_i,
    input  wire        wdog_clear_i,
    // Programming port for configuration space.
    input  wire [13:0] prog_addr_i,
    input  wire        prog_wr_i,
    input  wire [13:0] prog_wdata_i,
    output reg  [13:0] prog_rdata_o,
    output reg         prog_ack_o,
    // Status.
    output reg         core_reset_o,
    output reg         halted_o,
    output reg         wdog_reset_o,
    output reg         code_guard_on_o
);
    // One-hot sequencer states.
    localparam ST_OSC = 4'b0001;
    localparam ST_PWR = 4'b0010;
    localparam ST_RUN = 4'b0100;
    localparam ST_HLT = 4'b1000;

    // Terminal counts, all 32 bits wide; the watchdog compare uses only the low 16 bits.
    localparam [31:0] SETTLE_LAST = SETTLE_CYCLES - 1;
    localparam [31:0] PWRUP_LAST  = PWRUP_CYCLES - 1;
    localparam [31:0] WDOG_LAST   = WDOG_TICKS - 1;

    // Synchronised copies of the pins from outside the clock domain.
    wire        ext_rst_s;
    wire        prog_s;
    wire        rc_s;

    // Sequencer, option word and watchdog state.
    reg  [3:0]  state_q;
    reg  [31:0] cnt_q;
    reg         pwrup_q;
    reg  [13:0] opt_q;
    reg         rc_prev_q;
    reg  [15:0] wdog_q;

    // Pins from outside the clock domain are synchronised first; the external reset
    // is inverted so that the synchroniser's cleared state means no request.
    rsq_sync u_sync_ext (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (~ext_reset_n_i),
        .sync_o    (ext_rst_s)
    );
    rsq_sync u_sync_prog (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (prog_mode_i),
        .sync_o    (prog_s)
    );
    rsq_sync u_sync_rc (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (wdog_rc_clk_i),
        .sync_o    (rc_s)
    );

    // Address decode for the whole test and configuration space.
    function in_cfg_space;
        input [13:0] a;
        begin
            in_cfg_space = (a >= `RSQ_CFG_BASE) && (a <= `RSQ_CFG_LAST);
        end
    endfunction

    // Terminal-count test shared by the settle and power-up timers.
    function count_done;
        input [31:0] count;
        input [31:0] last;
        begin
            count_done = (count >= last);
        end
    endfunction

    // Option decode: an unprogrammed bit reads 1, so an erased word enables the watchdog.
    wire       wdog_en  = opt_q[`RSQ_BIT_WDOG_EN];
    wire       pwrup_en = ~opt_q[`RSQ_BIT_PWRUP_EN_N];
    wire [1:0] guard_lo = opt_q[`RSQ_GUARD_LO_MSB:`RSQ_GUARD_LO_LSB];
    wire [1:0] guard_hi = opt_q[`RSQ_GUARD_HI_MSB:`RSQ_GUARD_HI_LSB];

    // Watchdog decode: one rising edge of the RC clock is one tick, and the
    // timeout fires on the tick that would carry the count past its last value.
    wire       rc_tick  = rc_s & ~rc_prev_q;
    wire       wdog_to  = wdog_en && rc_tick &&
                          (wdog_q == WDOG_LAST[15:0]);

    // Option word: erased to all ones; programming clears bits, only in programming mode.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            opt_q <= `RSQ_OPT_ERASED;
            prog_ack_o <= 1'b0;
            prog_rdata_o <= 14'h0000;
        end else begin
            prog_ack_o <= prog_s && in_cfg_space(prog_addr_i);
            if (prog_s && prog_addr_i == `RSQ_OPT_ADDR) begin
                prog_rdata_o <= opt_q;
                if (prog_wr_i) begin
                    opt_q <= opt_q & prog_wdata_i;
                end
            end else begin
                prog_rdata_o <= 14'h0000;
            end
        end
    end

    // Watchdog counts RC ticks; nothing but the option word can disable it.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rc_prev_q <= 1'b0;
            wdog_q <= 16'h0000;
        end else begin
            rc_prev_q <= rc_s;
            if (!wdog_en || wdog_clear_i || core_reset_o || wdog_to) begin
                wdog_q <= 16'h0000;
            end else if (rc_tick) begin
                wdog_q <= wdog_q + 16'h0001;
            end
        end
    end

    // Sequencer: settle timer, then power-up delay on first start only.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_q <= ST_OSC;
            cnt_q <= 32'h0000_0000;
            pwrup_q <= 1'b1;
            core_reset_o <= 1'b1;
            halted_o <= 1'b0;
            wdog_reset_o <= 1'b0;
            code_guard_on_o <= 1'b0;
        end else begin
            code_guard_on_o <= (guard_lo != `RSQ_GUARD_OFF) ||
                               (guard_hi != `RSQ_GUARD_OFF);
            wdog_reset_o <= 1'b0;
            case (state_q)
                // Settle timer; a pending external reset keeps it at zero.
                ST_OSC: begin
                    core_reset_o <= 1'b1;
                    if (ext_rst_s) begin
                        cnt_q <= 32'h0000_0000;
                    end else if (count_done(cnt_q, SETTLE_LAST)) begin
                        cnt_q <= 32'h0000_0000;
                        if (pwrup_q && pwrup_en) begin
                            state_q <= ST_PWR;
                        end else begin
                            state_q <= ST_RUN;
                            core_reset_o <= 1'b0;
                        end
                        // Only the first settle after power-on may take the long delay.
                        pwrup_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                // Power-up delay; release waits while an external reset is pending.
                ST_PWR: begin
                    if (count_done(cnt_q, PWRUP_LAST)) begin
                        if (!ext_rst_s) begin
                            state_q <= ST_RUN;
                            core_reset_o <= 1'b0;
                        end
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                // Running; a timeout or external reset restarts the settle timer only.
                ST_RUN: begin
                    if (ext_rst_s || wdog_to) begin
                        wdog_reset_o <= wdog_to;
                        state_q <= ST_OSC;
                        core_reset_o <= 1'b1;
                        cnt_q <= 32'h0000_0000;
                    end else if (sleep_req_i) begin
                        state_q <= ST_HLT;
                        halted_o <= 1'b1;
                    end
                end
                ST_HLT: begin
                    // Wake on external reset, watchdog timeout, or interrupt.
                    if (ext_rst_s) begin
                        state_q <= ST_OSC;
                        core_reset_o <= 1'b1;
                        halted_o <= 1'b0;
                        cnt_q <= 32'h0000_0000;
                    end else if (wdog_to || irq_i) begin
                        wdog_reset_o <= wdog_to;
                        state_q <= ST_RUN;
                        halted_o <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_OSC;
                    core_reset_o <= 1'b1;
                end
            endcase
        end
    end
endmodule // rsq_reset_seq
`default_nettype wire

// file: bench/rsq_reset_seq_asserts.sv
// Checker for the start-up reset sequencer ports.
// Assumes it is bound to rsq_reset_seq and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module rsq_reset_seq_asserts #(
    parameter SETTLE_CYCLES = 16
) (
    // Clock, reset and inputs.
    input wire logic        mclk_i,
    input wire logic        reset_n_i,
    input wire logic        ext_reset_n_i,
    input wire logic        prog_mode_i,
    input wire logic        irq_i,
    input wire logic [13:0] prog_addr_i,
    // Outputs.
    input wire logic [13:0] prog_rdata_o,
    input wire logic        prog_ack_o,
    input wire logic        core_reset_o,
    input wire logic        halted_o,
    input wire logic        wdog_reset_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    logic [15:0] cnt_q;
    // Counts how long the core has been held, so a short settle shows up.
    always_ff @(posedge mclk_i) begin
        cnt_q <= (!reset_n_i || !core_reset_o) ? 16'h0000 : cnt_q + 16'h0001;
    end
    settle_hold_a: assert property ($fell(core_reset_o) |-> cnt_q >= SETTLE_CYCLES)
        else $error("core released before settle time");
    ack_range_a: assert property (prog_ack_o |-> $past(prog_addr_i) >= 14'h2000)
        else $error("ack outside configuration space");
    ack_mode_a: assert property (prog_ack_o |-> $past(prog_mode_i, 2) || $past(prog_mode_i, 3))
        else $error("ack without programming mode");
    word_addr_a: assert property (prog_rdata_o != 14'h0000 |-> $past(prog_addr_i) == 14'h2007)
        else $error("read data away from option word");
    irq_wake_a: assert property (halted_o && irq_i |-> ##[1:4] !halted_o)
        else $error("interrupt did not end halt");
    ext_hold_a: assert property (!ext_reset_n_i [*5] |-> core_reset_o)
        else $error("core not held by external reset");
    wdog_pulse_a: assert property (wdog_reset_o |=> !wdog_reset_o)
        else $error("watchdog pulse too long");
    wdog_reset_a: assert property (wdog_reset_o && !$past(halted_o) |-> ##[0:3] core_reset_o)
        else $error("watchdog timeout did not reset core");
    cover property (halted_o);
    cover property (wdog_reset_o);
    cover property (prog_ack_o);
    cover property (halted_o ##1 (wdog_reset_o && !core_reset_o));
endmodule // rsq_reset_seq_asserts
bind rsq_reset_seq rsq_reset_seq_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) rsq_chk_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ext_reset_n_i(ext_reset_n_i),
    .prog_mode_i(prog_mode_i), .irq_i(irq_i), .prog_addr_i(prog_addr_i),
    .prog_rdata_o(prog_rdata_o), .prog_ack_o(prog_ack_o), .core_reset_o(core_reset_o),
    .halted_o(halted_o), .wdog_reset_o(wdog_reset_o));
`default_nettype wire

// file: bench/rsq_prog_model.sv
// Device programmer model driving the configuration-space port.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module rsq_prog_model (
    // Clock.
    input  wire logic        mclk_i,
    // Programming port.
    output var  logic        mode_o,
    output var  logic        wr_o,
    output var  logic [13:0] addr_o,
    output var  logic [13:0] wdata_o
);
    // Idle port at time zero.
    initial {mode_o, wr_o, addr_o, wdata_o} = '0;
    // Mode settles through the synchroniser before any access follows.
    task automatic set_mode(input logic m);
        mode_o <= m;
        repeat (4) @(posedge mclk_i) #1;
    endtask
    // One access, held through the edge at which its registered answer is sampled;
    // the port then stays put until the next call, so nothing changes twice a step.
    task automatic acc(input logic [13:0] a, input logic w, input logic [13:0] d);
        addr_o <= a;
        wr_o <= w;
        wdata_o <= d;
        repeat (2) @(posedge mclk_i) #1;
    endtask
endmodule // rsq_prog_model
`default_nettype wire

// file: bench/rsq_reset_seq_tb.sv
// Self-checking bench for the reset sequencer.
// Assumes short timer parameters so the run stays brief.
`timescale 1ns/10ps
`default_nettype none
module rsq_reset_seq_tb;
    logic        mclk_i = 1'b0, reset_n_i = 1'b0, ext_n = 1'b1, rc = 1'b0, rc_on = 1'b0;
    logic        slp = 1'b0, irq = 1'b0, wclr = 1'b0, pm, wr, ack, crst, hlt, wrst, grd;
    logic [13:0] ad, wd, rd;
    int          error_cnt = 0, check_count = 0, n;
    // System clock and a gated RC clock unrelated in phase.
    always #5 mclk_i = ~mclk_i;
    always #37 if (rc_on) rc = ~rc;
    rsq_prog_model rsq_prog_model_inst (.mclk_i(mclk_i), .mode_o(pm), .wr_o(wr),
        .addr_o(ad), .wdata_o(wd));
    rsq_reset_seq #(.PWRUP_CYCLES(50), .SETTLE_CYCLES(16), .WDOG_TICKS(4)) rsq_reset_seq_inst (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ext_reset_n_i(ext_n), .wdog_rc_clk_i(rc),
        .prog_mode_i(pm), .sleep_req_i(slp), .irq_i(irq), .wdog_clear_i(wclr),
        .prog_addr_i(ad), .prog_wr_i(wr), .prog_wdata_i(wd), .prog_rdata_o(rd),
        .prog_ack_o(ack), .core_reset_o(crst), .halted_o(hlt), .wdog_reset_o(wrst),
        .code_guard_on_o(grd));
    task automatic chk(input string s, input logic [13:0] e, input logic [13:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    // Bounded wait for the core to leave reset.
    task automatic wait_rel();
        n = 0;
        while (crst !== 1'b0 && n < 300) begin
            @(posedge mclk_i) #1;
            n++;
        end
    endtask
    task automatic t_start();
        wait_rel();
        chk("start_len", 14'h0001, 14'(n >= 16 && n < 45));
        chk("guard_off", 14'h0000, 14'(grd));
        $display("test start done");
    endtask
    task automatic t_prog();
        rsq_prog_model_inst.set_mode(1'b1);
        rsq_prog_model_inst.acc(14'h2007, 1'b0, 14'h0000);
        chk("opt_ack", 14'h0001, 14'(ack));
        chk("opt_erased", 14'h3fff, rd);
        rsq_prog_model_inst.acc(14'h2007, 1'b1, 14'h3fc7);
        rsq_prog_model_inst.acc(14'h2007, 1'b0, 14'h0000);
        chk("opt_prog", 14'h3fc7, rd);
        chk("guard_on", 14'h0001, 14'(grd));
        rsq_prog_model_inst.acc(14'h2000, 1'b0, 14'h0000);
        chk("base_ack", 14'h0001, 14'(ack));
        rsq_prog_model_inst.acc(14'h1fff, 1'b0, 14'h0000);
        chk("user_ack", 14'h0000, 14'(ack));
        rsq_prog_model_inst.set_mode(1'b0);
        rsq_prog_model_inst.acc(14'h2007, 1'b0, 14'h0000);
        chk("run_ack", 14'h0000, 14'(ack));
        chk("run_data", 14'h0000, rd);
        $display("test prog done");
    endtask
    // Regular clears keep the running watchdog from ever timing out.
    task automatic t_clear();
        int seen;
        seen = 0;
        rc_on = 1'b1;
        for (int i = 0; i < 120; i++) begin
            wclr = (i % 10 == 0);
            @(posedge mclk_i) #1;
            if (wrst !== 1'b0 || crst !== 1'b0)
                seen++;
        end
        wclr = 1'b0;
        rc_on = 1'b0;
        chk("wdog_clear", 14'h0000, 14'(seen));
        $display("test clear done");
    endtask
    task automatic t_wdog();
        rc_on = 1'b1;
        n = 0;
        while (wrst !== 1'b1 && n < 300) begin
            @(posedge mclk_i) #1;
            n++;
        end
        rc_on = 1'b0;
        chk("wdog_fire", 14'h0001, 14'(n < 300));
        repeat (3) @(posedge mclk_i) #1;
        chk("wdog_hold", 14'h0001, 14'(crst));
        wait_rel();
        chk("wdog_len", 14'h0001, 14'(n >= 10 && n < 40));
        $display("test wdog done");
    endtask
    task automatic t_sleep();
        slp = 1'b1;
        @(posedge mclk_i) #1 slp = 1'b0;
        repeat (3) @(posedge mclk_i) #1;
        chk("halt", 14'h0001, 14'(hlt));
        irq = 1'b1;
        repeat (4) @(posedge mclk_i) #1 irq = 1'b0;
        chk("irq_wake", 14'h0000, 14'(hlt));
        slp = 1'b1;
        @(posedge mclk_i) #1 slp = 1'b0;
        rc_on = 1'b1;
        n = 0;
        while (hlt === 1'b1 && n < 300) begin
            @(posedge mclk_i) #1;
            n++;
        end
        rc_on = 1'b0;
        chk("wdog_wake", 14'h0001, 14'(wrst === 1'b1 && crst === 1'b0 && n < 300));
        slp = 1'b1;
        @(posedge mclk_i) #1 slp = 1'b0;
        ext_n = 1'b0;
        repeat (6) @(posedge mclk_i) #1;
        chk("ext_hold", 14'h0001, 14'(crst));
        ext_n = 1'b1;
        wait_rel();
        chk("ext_rel", 14'h0001, 14'(n >= 16 && n < 40));
        $display("test sleep done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence after the power-on reset.
    initial begin
        repeat (12) @(posedge mclk_i);
        #1 reset_n_i = 1'b1;
        t_start();
        t_prog();
        t_clear();
        t_wdog();
        t_sleep();
        end_sim();
    end
    // Hang guard, far beyond the few hundred cycles the tests need.
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule // rsq_reset_seq_tb
`default_nettype wire
